// ---- deep_power_down_control.sv ----
// Purpose: Deep sleep entry, command filtering and wake of a serial flash
// Assumes: Link logic runs on the serial clock, timing on ref_clk_i
// Notes: Frame byte and bit count are read only after chip select is seen high
`timescale 1ns/1ps
module deep_power_down_control
	import dpd_pkg::*;
#(
	parameter int POWERUP_WAIT_CYCLES = POWERUP_WAIT_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	dpd_link_if.device link,
	input wire logic op_in_progress_i,
	output logic deep_sleep_o,
	output logic standby_o,
	output logic ready_o,
	output logic cmd_valid_o,
	output logic [7:0] cmd_byte_o,
	output logic sleep_rejected_o,
	output logic soft_reset_o,
	output logic load_defaults_o
);
	typedef enum logic [2:0] {
		PWR_STANDBY,
		PWR_ENTERING,
		PWR_SLEEP,
		PWR_WAKING,
		PWR_POWERUP
	} pwr_state_e;

	// Serial clock domain
	logic armed_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic frame_tg_reg;

	// Set while chip select is high, so the first edge of a frame restarts the count
	always_ff @(posedge link.sclk or posedge link.cs_n or negedge rst_b_i) begin
		if (!rst_b_i) begin
			armed_reg <= 1'b1;
		end else if (link.cs_n) begin
			armed_reg <= 1'b1;
		end else begin
			armed_reg <= 1'b0;
		end
	end

	always_ff @(posedge link.sclk or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			frame_tg_reg <= 1'b0;
		end else if (!link.cs_n) begin
			if (armed_reg) begin
				bit_cnt_reg <= 4'h1;
				shift_reg <= {7'h00, link.mosi};
				frame_tg_reg <= ~frame_tg_reg;
			end else if (bit_cnt_reg < CMD_BITS) begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				shift_reg <= {shift_reg[6:0], link.mosi};
			end else begin
				// Extra bits mark the frame as overrun and keep the first byte
				bit_cnt_reg <= CMD_OVERRUN;
			end
		end
	end

	// Reference clock domain
	logic cs_q1_reg;
	logic cs_q2_reg;
	logic cs_q3_reg;
	logic cs_high_reg;
	logic tg_q1_reg;
	logic tg_q2_reg;
	logic tg_q3_reg;
	logic seen_tg_reg;
	pwr_state_e state_reg;
	logic [TIMER_W-1:0] timer_reg;
	logic reset_en_reg;
	logic deep_sleep_reg;
	logic standby_reg;
	logic ready_reg;
	logic cmd_valid_reg;
	logic [7:0] cmd_byte_reg;
	logic sleep_rejected_reg;
	logic soft_reset_reg;
	logic load_defaults_reg;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cs_q1_reg <= 1'b1;
			cs_q2_reg <= 1'b1;
			cs_q3_reg <= 1'b1;
			cs_high_reg <= 1'b1;
			tg_q1_reg <= 1'b0;
			tg_q2_reg <= 1'b0;
			tg_q3_reg <= 1'b0;
		end else begin
			cs_q1_reg <= link.cs_n;
			cs_q2_reg <= cs_q1_reg;
			cs_q3_reg <= cs_q2_reg;
			if (cs_q2_reg == cs_q3_reg) begin
				cs_high_reg <= cs_q3_reg;
			end
			tg_q1_reg <= frame_tg_reg;
			tg_q2_reg <= tg_q1_reg;
			tg_q3_reg <= tg_q2_reg;
		end
	end

	logic cs_rise;
	logic new_frame;
	logic whole_byte;
	logic exact_byte;
	logic is_sleep;
	logic is_wake;
	logic is_soft;
	logic is_ren;
	logic is_rst;
	logic asleep;
	logic start_sleep;
	logic start_wake;
	logic do_soft;
	logic do_reset;
	logic reject_sleep;
	logic forward;

	// Byte and count are static once chip select is high: the serial clock has stopped
	assign cs_rise = !cs_high_reg && cs_q2_reg && cs_q3_reg;
	// Toggle counts only once two samples agree, as chip select does
	assign new_frame = cs_rise && (tg_q2_reg == tg_q3_reg) && (tg_q3_reg != seen_tg_reg);
	assign whole_byte = new_frame && (bit_cnt_reg >= CMD_BITS);
	assign exact_byte = new_frame && (bit_cnt_reg == CMD_BITS);
	assign is_sleep = exact_byte && (shift_reg == CMD_DEEP_SLEEP);
	assign is_wake = whole_byte && (shift_reg == CMD_WAKE);
	assign is_soft = whole_byte && (shift_reg == CMD_SOFT_RESET);
	assign is_ren = whole_byte && (shift_reg == CMD_RESET_ENABLE);
	assign is_rst = whole_byte && (shift_reg == CMD_RESET) && reset_en_reg;
	assign asleep = (state_reg == PWR_SLEEP) || (state_reg == PWR_ENTERING);
	assign start_sleep = (state_reg == PWR_STANDBY) && is_sleep && !op_in_progress_i;
	assign reject_sleep = (state_reg == PWR_STANDBY) && is_sleep && op_in_progress_i;
	assign start_wake = asleep && is_wake && !op_in_progress_i;
	assign do_soft = asleep && is_soft;
	assign do_reset = ((state_reg == PWR_STANDBY) || asleep) && is_rst;
	// Exact eight-bit deep sleep frames and those outside standby are never passed to the array
	assign forward = (state_reg == PWR_STANDBY) && whole_byte && !is_sleep && !is_rst;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			seen_tg_reg <= 1'b0;
		end else if (cs_rise) begin
			seen_tg_reg <= tg_q3_reg;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reset_en_reg <= 1'b0;
		end else if (whole_byte) begin
			if ((state_reg == PWR_STANDBY) || asleep) begin
				reset_en_reg <= is_ren;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= PWR_STANDBY;
			timer_reg <= '0;
		end else begin
			unique case (state_reg)
				PWR_STANDBY: begin
					if (do_reset) begin
						state_reg <= PWR_POWERUP;
						timer_reg <= TIMER_W'(POWERUP_WAIT_CYCLES - 1);
					end else if (start_sleep) begin
						state_reg <= PWR_ENTERING;
						// Sync latency is taken off so the bound holds from the pin
						timer_reg <= TIMER_W'(SLEEP_ENTRY_CYC - CS_SYNC_CYC - 1);
					end
				end
				PWR_ENTERING, PWR_SLEEP: begin
					if (do_reset) begin
						state_reg <= PWR_POWERUP;
						timer_reg <= TIMER_W'(POWERUP_WAIT_CYCLES - 1);
					end else if (do_soft) begin
						state_reg <= PWR_STANDBY;
					end else if (start_wake) begin
						state_reg <= PWR_WAKING;
						timer_reg <= TIMER_W'(WAKE_DELAY_CYC - CS_SYNC_CYC - 1);
					end else if (state_reg == PWR_ENTERING) begin
						if (timer_reg == '0) begin
							state_reg <= PWR_SLEEP;
						end else begin
							timer_reg <= timer_reg - 1'b1;
						end
					end
				end
				PWR_WAKING, PWR_POWERUP: begin
					// Frames sent during the wait are dropped; the host must keep quiet
					if (timer_reg == '0) begin
						state_reg <= PWR_STANDBY;
					end else begin
						timer_reg <= timer_reg - 1'b1;
					end
				end
				default: begin
					state_reg <= PWR_STANDBY;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			deep_sleep_reg <= 1'b0;
			standby_reg <= 1'b1;
			ready_reg <= 1'b1;
		end else begin
			deep_sleep_reg <= (state_reg == PWR_SLEEP);
			standby_reg <= cs_high_reg && !op_in_progress_i && (state_reg == PWR_STANDBY);
			ready_reg <= (state_reg == PWR_STANDBY);
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_valid_reg <= 1'b0;
			cmd_byte_reg <= 8'h00;
			sleep_rejected_reg <= 1'b0;
			soft_reset_reg <= 1'b0;
			load_defaults_reg <= 1'b0;
		end else begin
			cmd_valid_reg <= forward;
			if (forward) begin
				cmd_byte_reg <= shift_reg;
			end
			sleep_rejected_reg <= reject_sleep;
			soft_reset_reg <= do_soft;
			load_defaults_reg <= do_reset;
		end
	end

	assign deep_sleep_o = deep_sleep_reg;
	assign standby_o = standby_reg;
	assign ready_o = ready_reg;
	assign cmd_valid_o = cmd_valid_reg;
	assign cmd_byte_o = cmd_byte_reg;
	assign sleep_rejected_o = sleep_rejected_reg;
	assign soft_reset_o = soft_reset_reg;
	assign load_defaults_o = load_defaults_reg;
endmodule // deep_power_down_control

// ---- dpd_pkg.sv ----
// Purpose: Shared constants for the deep sleep controller and its serial host
// Assumes: Reference clock of 20 MHz on both ends
// Notes: Times are in ns; cycle counts are derived from them
package dpd_pkg;
	localparam logic [7:0] CMD_DEEP_SLEEP = 8'hb9;
	localparam logic [7:0] CMD_WAKE = 8'hab;
	localparam logic [7:0] CMD_SOFT_RESET = 8'hff;
	localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
	localparam logic [7:0] CMD_RESET = 8'h99;
	localparam logic [3:0] CMD_BITS = 4'h8;
	localparam logic [3:0] CMD_OVERRUN = 4'h9;
	localparam int REF_CLK_PERIOD_NS = 50;
	localparam int SLEEP_ENTRY_DELAY_NS = 3000;
	localparam int WAKE_DELAY_NS = 30000;
	localparam int POWERUP_WAIT_NS = 2000000;
	localparam int CS_HIGH_NS = 20;
	// Longest times round down
	localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_DELAY_NS / REF_CLK_PERIOD_NS;
	localparam int WAKE_DELAY_CYC = WAKE_DELAY_NS / REF_CLK_PERIOD_NS;
	// Least times round up; chip select high is also held to at least one cycle
	localparam int POWERUP_WAIT_CYC = (POWERUP_WAIT_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
	localparam int CS_HIGH_RAW = (CS_HIGH_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
	localparam int CS_HIGH_CYC = (CS_HIGH_RAW < 1) ? 1 : CS_HIGH_RAW;
	localparam int WAKE_HOLD_CYC = (WAKE_DELAY_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
	// Chip select rise to a registered output, timer load cycle excluded
	localparam int CS_SYNC_CYC = 5;
	localparam int TIMER_W = 16;
endpackage

// ---- dpd_link_if.sv ----
// Purpose: Serial link between the flash host and the deep sleep controller
// Assumes: Single data line, host drives all three wires
// Notes: No clocking block; each end registers its own side
`timescale 1ns/1ps
interface dpd_link_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	modport host (output cs_n, output sclk, output mosi);
	modport device (input cs_n, input sclk, input mosi);
endinterface // dpd_link_if

// ---- dpd_serial_host.sv ----
// Purpose: Serial host that sends one command byte per chip select frame
// Assumes: Serial clock is ref_clk_i divided by two
// Notes: Holds chip select high for the wake delay after a wake byte
`timescale 1ns/1ps
module dpd_serial_host
	import dpd_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	dpd_link_if.host link,
	input wire logic req_valid_i,
	input wire logic [7:0] req_byte_i,
	output logic req_ready_o,
	output logic done_o
);
	typedef enum logic [2:0] {
		HST_IDLE,
		HST_SELECT,
		HST_SHIFT,
		HST_END,
		HST_GAP
	} hst_state_e;

	hst_state_e state_reg;
	logic cs_n_reg;
	logic sclk_reg;
	logic mosi_reg;
	logic [7:0] byte_reg;
	logic [2:0] bit_idx_reg;
	logic [TIMER_W-1:0] gap_reg;
	logic ready_reg;
	logic done_reg;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= HST_IDLE;
			cs_n_reg <= 1'b1;
			sclk_reg <= 1'b0;
			mosi_reg <= 1'b0;
			byte_reg <= 8'h00;
			bit_idx_reg <= 3'h7;
			gap_reg <= '0;
		end else begin
			unique case (state_reg)
				HST_IDLE: begin
					if (req_valid_i) begin
						byte_reg <= req_byte_i;
						state_reg <= HST_SELECT;
					end
				end
				HST_SELECT: begin
					cs_n_reg <= 1'b0;
					mosi_reg <= byte_reg[7];
					bit_idx_reg <= 3'h7;
					state_reg <= HST_SHIFT;
				end
				HST_SHIFT: begin
					if (!sclk_reg) begin
						sclk_reg <= 1'b1;
					end else begin
						sclk_reg <= 1'b0;
						if (bit_idx_reg == 3'h0) begin
							state_reg <= HST_END;
						end else begin
							bit_idx_reg <= bit_idx_reg - 3'h1;
							mosi_reg <= byte_reg[bit_idx_reg - 3'h1];
						end
					end
				end
				HST_END: begin
					// Raised right after the eighth bit, so no stray clock follows
					cs_n_reg <= 1'b1;
					if (byte_reg == CMD_WAKE) begin
						gap_reg <= TIMER_W'(WAKE_HOLD_CYC - 1);
					end else begin
						gap_reg <= TIMER_W'(CS_HIGH_CYC - 1);
					end
					state_reg <= HST_GAP;
				end
				HST_GAP: begin
					if (gap_reg == '0) begin
						state_reg <= HST_IDLE;
					end else begin
						gap_reg <= gap_reg - 1'b1;
					end
				end
				default: begin
					state_reg <= HST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ready_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			ready_reg <= (state_reg == HST_IDLE) && !req_valid_i;
			done_reg <= (state_reg == HST_GAP) && (gap_reg == '0);
		end
	end

	assign link.cs_n = cs_n_reg;
	assign link.sclk = sclk_reg;
	assign link.mosi = mosi_reg;
	assign req_ready_o = ready_reg;
	assign done_o = done_reg;
endmodule // dpd_serial_host

// ---- dpd_link_chk.sv ----
// Purpose: Link wire and power state checks
// Assumes: Link wires sampled on ref_clk_i
// Notes: Counters replace long repetitions
`timescale 1ns/1ps
module dpd_link_chk (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic mosi_i,
	input wire logic op_in_progress_i,
	input wire logic deep_sleep_i,
	input wire logic standby_i,
	input wire logic ready_i,
	input wire logic sleep_rejected_i
);
	logic sclk_reg;
	logic [3:0] bits_reg;
	logic [7:0] high_reg;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	// Serial rising edges in the open frame
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) sclk_reg <= 1'b0;
		else sclk_reg <= sclk_i;
		if (!rst_b_i) bits_reg <= 4'h0;
		else if (cs_n_i) bits_reg <= 4'h0;
		else if (sclk_i && !sclk_reg) bits_reg <= bits_reg + 4'h1;
	end
	// Saturates so a long idle cannot wrap into the entry window
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) high_reg <= 8'h00;
		else if (!cs_n_i) high_reg <= 8'h00;
		else if (high_reg != 8'hff) high_reg <= high_reg + 8'h01;
	end
	a_sclk_idle_low: assert property (cs_n_i |-> !sclk_i)
		else $error("sclk high while idle");
	a_mosi_held: assert property (sclk_i |-> $stable(mosi_i))
		else $error("mosi moved with sclk high");
	a_eight_bits: assert property ($rose(cs_n_i) |-> bits_reg == 4'h8)
		else $error("frame not eight bits");
	// Entry may be early but never later than 60 reference cycles after the rise
	a_entry_wait: assert property ($rose(deep_sleep_i) |->
		high_reg >= 8'h37 && high_reg <= 8'h3c) else $error("entry delay off");
	a_asleep_idle: assert property (deep_sleep_i |-> !ready_i && !standby_i)
		else $error("ready while asleep");
	// Standby follows the synchronised chip select, five samples behind the pin
	a_standby_cause: assert property (standby_i |->
		$past(cs_n_i, 5) && !$past(op_in_progress_i)) else $error("standby without idle");
	a_busy_frozen: assert property (op_in_progress_i |=> $stable(deep_sleep_i))
		else $error("sleep state moved while busy");
	a_reject_cause: assert property (sleep_rejected_i |->
		$past(op_in_progress_i) && !deep_sleep_i) else $error("bad reject");
	a_wake_bounded: assert property (!ready_i && !deep_sleep_i |->
		##[0:600] (ready_i || deep_sleep_i)) else $error("no resume in time");
endmodule // dpd_link_chk

// ---- deep_power_down_control_tb_top.sv ----
// Purpose: Host and device joined by the link, checked from the user sides
// Assumes: Power-up wait cut to 50 cycles
// Notes: Second device takes raw frames on a 30 ns link clock
`timescale 1ns/1ps
module deep_power_down_control_tb_top;
	typedef struct {logic [7:0] cmd; logic busy; logic ds; logic cv;} row_s;
	row_s rows [13] = '{'{8'h03, '0, '0, '1}, '{8'hb9, '1, '0, 'x}, '{8'hb9, '0, '1, 'x},
		'{8'h06, '0, '1, '0}, '{8'h02, '0, '1, '0}, '{8'hd8, '0, '1, '0}, '{8'hab, '1, '1, '0},
		'{8'hab, '0, '0, 'x}, '{8'hb9, '0, '1, 'x}, '{8'hff, '0, '0, 'x}, '{8'hb9, '0, '1, 'x},
		'{8'h66, '0, '1, 'x}, '{8'h99, '0, '0, 'x}};
	int bits_t [5] = '{9, 7, 0, 8, 8};
	logic [8:0] dat_t [5] = '{9'h172, 9'h05c, 9'h000, 9'h09d, 9'h0b9};
	row_s r;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic op = 1'b0;
	logic req_valid = 1'b0;
	logic [7:0] req_byte = 8'h00;
	logic [3:0] seen = 4'h0;
	logic clr_seen = 1'b0;
	logic req_ready, done, ds, sb, rdy, cv, rej, srst, ld, ds2;
	logic [7:0] cb;
	int error_cnt = 0;
	int num_checks = 0;
	int c;
	dpd_link_if link ();
	dpd_link_if link2 ();
	always #25 ref_clk = ~ref_clk;
	// Pulses last one cycle, so they are latched here
	always @(posedge ref_clk) seen <= (clr_seen ? 4'h0 : seen) | {ld, srst, rej, cv};
	dpd_serial_host u_dpd_serial_host (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .link(link),
		.req_valid_i(req_valid), .req_byte_i(req_byte), .req_ready_o(req_ready), .done_o(done));
	deep_power_down_control #(.POWERUP_WAIT_CYCLES(50)) u_deep_power_down_control (
		.ref_clk_i(ref_clk), .rst_b_i(rst_b), .link(link), .op_in_progress_i(op),
		.deep_sleep_o(ds), .standby_o(sb), .ready_o(rdy), .cmd_valid_o(cv), .cmd_byte_o(cb),
		.sleep_rejected_o(rej), .soft_reset_o(srst), .load_defaults_o(ld));
	deep_power_down_control #(.POWERUP_WAIT_CYCLES(50)) u_deep_power_down_control2 (
		.ref_clk_i(ref_clk), .rst_b_i(rst_b), .link(link2), .op_in_progress_i(1'b0),
		.deep_sleep_o(ds2), .standby_o(), .ready_o(), .cmd_valid_o(), .cmd_byte_o(),
		.sleep_rejected_o(), .soft_reset_o(), .load_defaults_o());
	dpd_link_chk u_dpd_link_chk (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .cs_n_i(link.cs_n),
		.sclk_i(link.sclk), .mosi_i(link.mosi), .op_in_progress_i(op), .deep_sleep_i(ds),
		.standby_i(sb), .ready_i(rdy), .sleep_rejected_i(rej));
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic pick(input int k);
		case (k)
			0: return req_ready;
			1: return done;
			2: return link.cs_n;
			3: return rdy;
			default: return !link.cs_n;
		endcase
	endfunction
	task automatic wait_for(input int k, output int n);
		for (n = 0; n < 2000 && pick(k) !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		if (pick(k) !== 1'b1) begin
			error_cnt++;
			$display("BAD wait %0d expected 1 seen 0", k);
			report_and_stop();
		end
	endtask
	task automatic send(input logic [7:0] b);
		int n;
		wait_for(0, n);
		req_valid = 1'b1;
		req_byte = b;
		clr_seen = 1'b1;
		@(posedge ref_clk);
		#1;
		req_valid = 1'b0;
		clr_seen = 1'b0;
		wait_for(1, n);
	endtask
	// Released data line shows the inverse of its last bit
	task automatic raw(input int bits, input logic [8:0] d);
		link2.cs_n = 1'b0;
		for (int k = bits - 1; k >= 0; k--) begin
			link2.mosi = d[k];
			#15;
			link2.sclk = 1'b1;
			#15;
			link2.sclk = 1'b0;
		end
		#15;
		link2.cs_n = 1'b1;
		link2.mosi = ~link2.mosi;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	initial begin
		link2.cs_n = 1'b1;
		link2.sclk = 1'b0;
		link2.mosi = 1'b0;
		settle(8);
		rst_b = 1'b1;
		settle(4);
		foreach (rows[i]) begin
			r = rows[i];
			op = r.busy;
			send(r.cmd);
			settle(80);
			chk("deep_sleep", ds, r.ds);
			chk("ready", rdy, !r.ds);
			chk("standby", sb, !r.ds && !r.busy);
			chk("rejected", seen[1], r.cmd == 8'hb9 && r.busy);
			chk("soft_reset", seen[2], r.cmd == 8'hff);
			chk("defaults", seen[3], r.cmd == 8'h99);
			if (r.cv !== 1'bx) chk("cmd_valid", seen[0], r.cv);
			if (r.cv === 1'b1) chk("cmd_byte", cb, r.cmd);
			op = 1'b0;
		end
		send(8'hb9);
		settle(80);
		fork
			send(8'hab);
			begin
				wait_for(4, c);
				wait_for(2, c);
				wait_for(3, c);
				chk("wake_time", c >= 595 && c <= 600, 1'b1);
			end
		join
		send(8'hb9);
		settle(80);
		chk("asleep", ds, 1'b1);
		rst_b = 1'b0;
		settle(2);
		chk("reset_sleep", ds, 1'b0);
		chk("reset_ready", rdy, 1'b1);
		rst_b = 1'b1;
		settle(4);
		chk("powerup_standby", sb, 1'b1);
		foreach (bits_t[i]) begin
			raw(bits_t[i], dat_t[i]);
			settle(100);
			chk("raw_sleep", ds2, i == 4);
		end
		report_and_stop();
	end
endmodule // deep_power_down_control_tb_top
